// File: rnq_top.sv
// reservation notification queue with apb register access
// Behaviour
// R1 - a retrieval request naming log identifier 80h is served by this queue.
// R2 - each unmasked reservation event appends a new record at the tail.
// R3 - a retrieval returns the oldest record, the one with lowest count.
// R4 - the returned record is removed so it is delivered only once.
// R5 - a retrieval on an empty queue returns an all-zero record.
// R6 - an event arriving while the queue is full is discarded.
// R7 - a discarded event raises the newest record's count to its own count.
// R8 - a 64-bit unique count sits in bytes 7 to 0 of each record.
// R9 - the unique count is zero after controller reset.
// R10 - the count advances for every unmasked event, stored or lost.
// R11 - past its maximum the count wraps to one, never zero.
// R12 - returning an empty record leaves the counter untouched.
// R13 - byte 8 holds type 0 empty, 1 registration preempted, 2 released.
// R14 - byte 9 holds the number of records still queued, saturating at 255.
// R15 - bytes 15 to 12 hold the namespace identifier of the event.
// R16 - queue depth is a parameter and full and empty come from pointers.
`timescale 1ns/1ns
module rnq_top
   import rnq_pkg::*;
#(
   parameter int DEPTH = 4
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ev_valid,
   input wire logic [7:0] ev_type,
   input wire logic [31:0] ev_nsid,
   output logic irq
);
   localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   typedef logic [IW:0] rnq_ptr_t;

   // wrap bit on top, index below; index never reaches DEPTH
   function automatic rnq_ptr_t rnq_inc(input rnq_ptr_t p);
      if (p[IW-1:0] == IW'(DEPTH - 1)) begin
         rnq_inc = {~p[IW], {IW{1'b0}}};
      end else begin
         rnq_inc = p + rnq_ptr_t'(1);
      end
   endfunction : rnq_inc

   function automatic int rnq_occ(input rnq_ptr_t w, input rnq_ptr_t r);
      if (w[IW] == r[IW]) begin
         rnq_occ = int'(w[IW-1:0]) - int'(r[IW-1:0]);
      end else begin
         rnq_occ = DEPTH - int'(r[IW-1:0]) + int'(w[IW-1:0]);
      end
   endfunction : rnq_occ

   // a write access landing on one register offset
   function automatic logic rnq_wr_hit(input logic w, input logic [11:0] a,
                                       input logic [11:0] ofs);
      rnq_wr_hit = w && (a == ofs);
   endfunction : rnq_wr_hit

   // records left behind the one handed out, clipped to one byte
   function automatic logic [7:0] rnq_left(input int n);
      if (n <= 1) begin
         rnq_left = 8'h00;
      end else if ((n - 1) > int'(RNQ_AVAIL_MAX)) begin
         rnq_left = RNQ_AVAIL_MAX;
      end else begin
         rnq_left = 8'(n - 1);
      end
   endfunction : rnq_left

   logic [63:0] mem_cnt [DEPTH];
   logic [7:0] mem_type [DEPTH];
   logic [31:0] mem_nsid [DEPTH];

   rnq_ptr_t wptr, next_wptr, rptr, next_rptr;
   logic [63:0] cnt, next_cnt;
   logic [63:0] res_cnt, next_res_cnt;
   logic [7:0] res_type, next_res_type;
   logic [7:0] res_avail, next_res_avail;
   logic [31:0] res_nsid, next_res_nsid;
   logic [7:0] nmask, next_nmask;
   logic [3:0] istat, next_istat;
   logic [3:0] imask, next_imask;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr, next_irq;

   logic access, wr, req_wr, retrieve, bad_id;
   logic empty, full, ev_ok, pop, push, lost;
   logic [63:0] cnt_new;
   logic [IW-1:0] last_idx;
   logic mem_we_rec, mem_we_cnt;
   logic [IW-1:0] mem_idx;
   logic [63:0] mem_wcnt;
   int occ;

   // queue and counter
   always_comb begin
      access = psel && penable && pready;
      wr = access && pwrite;
      req_wr = rnq_wr_hit(wr, paddr, RNQ_OFS_REQ);
      retrieve = req_wr && (pwdata[7:0] == RNQ_LOG_ID); // R1
      bad_id = req_wr && (pwdata[7:0] != RNQ_LOG_ID);
      empty = (wptr == rptr); // R16
      // same index with differing wrap bits means every slot is taken
      full = (wptr[IW-1:0] == rptr[IW-1:0]) && (wptr[IW] != rptr[IW]); // R16
      occ = rnq_occ(wptr, rptr);
      // types above seven have no mask bit, so they always pass
      ev_ok = ev_valid && !((ev_type < 8'h08) && nmask[ev_type[2:0]]);
      pop = retrieve && !empty;
      // a pop in the same cycle frees the slot, so the event still fits
      push = ev_ok && (!full || pop); // R2
      lost = ev_ok && full && !pop; // R6
      if (cnt == RNQ_CNT_MAX) begin
         cnt_new = RNQ_CNT_WRAP; // R11
      end else begin
         cnt_new = cnt + 64'h1;
      end
      // newest stored entry, the one a lost event rewrites
      if (wptr[IW-1:0] == {IW{1'b0}}) begin
         last_idx = IW'(DEPTH - 1);
      end else begin
         last_idx = wptr[IW-1:0] - IW'(1);
      end
      next_cnt = ev_ok ? cnt_new : cnt; // R10 R12
      next_wptr = push ? rnq_inc(wptr) : wptr; // R2
      next_rptr = pop ? rnq_inc(rptr) : rptr; // R4
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wptr <= '0;
         rptr <= '0;
         cnt <= RNQ_CNT_RESET; // R9
      end else begin
         wptr <= next_wptr;
         rptr <= next_rptr;
         cnt <= next_cnt;
      end
   end

   // storage write port; a lost event only rewrites the newest count
   always_comb begin
      mem_we_rec = push; // R2
      mem_we_cnt = push || lost; // R7
      mem_idx = push ? wptr[IW-1:0] : last_idx; // R7
      mem_wcnt = cnt_new; // R8
   end

   // storage has no reset; only entries between the pointers are ever read
   always_ff @(posedge clock) begin
      if (mem_we_cnt) begin
         mem_cnt[mem_idx] <= mem_wcnt;
      end
      if (mem_we_rec) begin
         mem_type[mem_idx] <= ev_type; // R13
         mem_nsid[mem_idx] <= ev_nsid; // R15
      end
   end

   // result is held until the next retrieval, so both halves agree
   always_comb begin
      next_res_cnt = res_cnt;
      next_res_type = res_type;
      next_res_avail = res_avail;
      next_res_nsid = res_nsid;
      if (retrieve && empty) begin
         next_res_cnt = 64'h0; // R5
         next_res_type = RNQ_TYPE_EMPTY; // R5 R13
         next_res_avail = 8'h00;
         next_res_nsid = 32'h0;
      end else if (pop) begin
         next_res_cnt = mem_cnt[rptr[IW-1:0]]; // R3 R8
         next_res_type = mem_type[rptr[IW-1:0]]; // R13
         next_res_avail = rnq_left(occ); // R14
         next_res_nsid = mem_nsid[rptr[IW-1:0]]; // R15
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         res_cnt <= RNQ_CNT_RESET;
         res_type <= RNQ_TYPE_EMPTY;
         res_avail <= RNQ_AVAIL_RST;
         res_nsid <= RNQ_NSID_RST;
      end else begin
         res_cnt <= next_res_cnt;
         res_type <= next_res_type;
         res_avail <= next_res_avail;
         res_nsid <= next_res_nsid;
      end
   end

   // apb slave, control and interrupt registers
   always_comb begin
      // one wait state on every access; pready stands for a single cycle
      next_pready = psel && penable && !pready;
      next_prdata = prdata;
      next_pslverr = pslverr;
      if (psel && penable && !pready) begin
         next_pslverr = 1'b0;
         next_prdata = 32'h0;
         case (paddr)
            RNQ_OFS_REQ: begin
               next_prdata = 32'h0;
            end
            RNQ_OFS_CNT_LO: begin
               next_prdata = res_cnt[31:0];
            end
            RNQ_OFS_CNT_HI: begin
               next_prdata = res_cnt[63:32];
            end
            RNQ_OFS_INFO: begin
               next_prdata[RNQ_INFO_TYPE_LSB +: 8] = res_type; // R13
               next_prdata[RNQ_INFO_AVAIL_LSB +: 8] = res_avail; // R14
            end
            RNQ_OFS_NSID: begin
               next_prdata = res_nsid;
            end
            RNQ_OFS_LEVEL: begin
               next_prdata = 32'(occ);
            end
            RNQ_OFS_NMASK: begin
               next_prdata = {24'h0, nmask};
            end
            RNQ_OFS_IRQ_STAT: begin
               next_prdata = {28'h0, istat};
            end
            RNQ_OFS_IRQ_MASK: begin
               next_prdata = {28'h0, imask};
            end
            default: begin
               next_pslverr = 1'b1;
            end
         endcase
      end else if (!psel) begin
         next_pslverr = 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prdata <= RNQ_PRDATA_RST;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // mask and status registers
   always_comb begin
      next_nmask = nmask;
      next_imask = imask;
      next_istat = istat;
      if (rnq_wr_hit(wr, paddr, RNQ_OFS_NMASK)) begin
         next_nmask = pwdata[7:0]; // R2
      end
      if (rnq_wr_hit(wr, paddr, RNQ_OFS_IRQ_MASK)) begin
         next_imask = pwdata[RNQ_IRQ_W-1:0];
      end
      if (rnq_wr_hit(wr, paddr, RNQ_OFS_IRQ_STAT)) begin
         next_istat = istat & ~pwdata[RNQ_IRQ_W-1:0];
      end
      // events set after the clear so a same-cycle event is kept
      next_istat[RNQ_IRQ_STORED] = next_istat[RNQ_IRQ_STORED] | push;
      next_istat[RNQ_IRQ_LOST] = next_istat[RNQ_IRQ_LOST] | lost;
      next_istat[RNQ_IRQ_DONE] = next_istat[RNQ_IRQ_DONE] | retrieve;
      next_istat[RNQ_IRQ_BADID] = next_istat[RNQ_IRQ_BADID] | bad_id;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         nmask <= RNQ_NMASK_RST;
         imask <= RNQ_IMASK_RST;
         istat <= RNQ_ISTAT_RST;
      end else begin
         nmask <= next_nmask;
         imask <= next_imask;
         istat <= next_istat;
      end
   end

   // interrupt level, taken from the next status so it rises with the bit
   always_comb begin
      next_irq = |(next_istat & next_imask);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end
endmodule : rnq_top

// File: rnq_pkg.sv
// constants shared by the reservation notification queue
package rnq_pkg;
   localparam logic [7:0] RNQ_LOG_ID = 8'h80;
   localparam logic [11:0] RNQ_OFS_REQ = 12'h000;
   localparam logic [11:0] RNQ_OFS_CNT_LO = 12'h004;
   localparam logic [11:0] RNQ_OFS_CNT_HI = 12'h008;
   localparam logic [11:0] RNQ_OFS_INFO = 12'h00c;
   localparam logic [11:0] RNQ_OFS_NSID = 12'h010;
   localparam logic [11:0] RNQ_OFS_LEVEL = 12'h014;
   localparam logic [11:0] RNQ_OFS_NMASK = 12'h018;
   localparam logic [11:0] RNQ_OFS_IRQ_STAT = 12'h01c;
   localparam logic [11:0] RNQ_OFS_IRQ_MASK = 12'h020;
   localparam logic [7:0] RNQ_TYPE_EMPTY = 8'h00;
   localparam logic [7:0] RNQ_TYPE_PREEMPT = 8'h01;
   localparam logic [7:0] RNQ_TYPE_RELEASE = 8'h02;
   localparam logic [7:0] RNQ_AVAIL_MAX = 8'hff;
   localparam logic [63:0] RNQ_CNT_RESET = 64'h0;
   localparam logic [63:0] RNQ_CNT_WRAP = 64'h1;
   localparam logic [63:0] RNQ_CNT_MAX = 64'hffffffffffffffff;
   localparam int RNQ_IRQ_W = 4;
   localparam int RNQ_IRQ_STORED = 0;
   localparam int RNQ_IRQ_LOST = 1;
   localparam int RNQ_IRQ_DONE = 2;
   localparam int RNQ_IRQ_BADID = 3;
   localparam logic [7:0] RNQ_NMASK_RST = 8'h00;
   localparam logic [3:0] RNQ_IMASK_RST = 4'h0;
   localparam logic [3:0] RNQ_ISTAT_RST = 4'h0;
   localparam logic [7:0] RNQ_AVAIL_RST = 8'h00;
   localparam logic [31:0] RNQ_NSID_RST = 32'h0;
   localparam logic [31:0] RNQ_PRDATA_RST = 32'h0;
   localparam int RNQ_INFO_TYPE_LSB = 0;
   localparam int RNQ_INFO_AVAIL_LSB = 8;
endpackage : rnq_pkg

// File: rnq_properties.sv
// concurrent checks on the queue's register bus ports
`timescale 1ns/1ns
module rnq_properties
   import rnq_pkg::*;
#(
   parameter int DEPTH = 4
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic ev_valid,
   input wire logic [7:0] ev_type,
   input wire logic [31:0] ev_nsid,
   input wire logic irq
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   a_ready_access: assert property (psel && penable && !pready |=> pready)
      else $error("ready late");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held");
   a_ready_cause: assert property (pready |-> $past(psel && penable))
      else $error("ready without access");
   a_err_unmapped: assert property (pready && paddr > RNQ_OFS_IRQ_MASK |-> pslverr)
      else $error("unmapped not refused");
   a_err_mapped: assert property (pready && paddr <= RNQ_OFS_IRQ_MASK
      && paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped refused");
   a_req_zero: assert property (pready && !pwrite && paddr == RNQ_OFS_REQ
      |-> prdata == 32'h0) else $error("request reads nonzero");
   a_type_known: assert property (pready && !pwrite && paddr == RNQ_OFS_INFO
      |-> prdata[7:0] <= RNQ_TYPE_RELEASE) else $error("bad type");
   a_level_bound: assert property (pready && !pwrite && paddr == RNQ_OFS_LEVEL
      |-> prdata <= 32'(DEPTH)) else $error("level over depth");
   c_read: cover property (pready && !pwrite);
   c_err: cover property (pready && pslverr);
   c_irq: cover property ($rose(irq));
endmodule : rnq_properties

// File: rnq_host.sv
// host model issuing apb transfers toward the queue
`timescale 1ns/1ns
module rnq_host (
   input wire logic clock,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 12'h000;
      pwdata <= 32'h0;
   end
   // an idle edge first, so a release never meets a new setup in one step
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : rnq_host

// File: test_reservation_notification_queue.sv
// self-checking bench for the reservation notification queue
`timescale 1ns/1ns
module test_reservation_notification_queue
   import rnq_pkg::*;
;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic ev_valid = 1'b0;
   logic [7:0] ev_type = 8'h00;
   logic [31:0] ev_nsid = 32'h0;
   logic psel, penable, pwrite, pready, pslverr, irq, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   int num_errors = 0;
   int samples_checked = 0;
   logic [43:0] rows [8] = '{{RNQ_OFS_CNT_LO, 32'h0}, {RNQ_OFS_CNT_HI, 32'h0},
      {RNQ_OFS_INFO, 32'h0}, {RNQ_OFS_NSID, 32'h0}, {RNQ_OFS_LEVEL, 32'h0},
      {RNQ_OFS_NMASK, 32'h0}, {RNQ_OFS_IRQ_STAT, 32'h0},
      {RNQ_OFS_IRQ_MASK, 32'h0}};
   always #20 clock = ~clock;
   // depth two so three events already overflow the queue
   rnq_top #(.DEPTH(2)) DUT (.clock, .rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .ev_valid, .ev_type, .ev_nsid, .irq);
   rnq_host host (.clock, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr);
   task chk(input logic [63:0] s, input logic [63:0] x);
      samples_checked++;
      if (s !== x) begin
         num_errors++;
         $display("[FAIL] %0t seen %h want %h", $time, s, x);
      end
   endtask : chk
   task rd(input logic [11:0] a, input logic [31:0] x);
      host.xfer(1'b0, a, 32'h0, q, e);
      chk(64'(q), 64'(x));
   endtask : rd
   task wr(input logic [11:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, q, e);
   endtask : wr
   task ev(input logic [7:0] t, input logic [31:0] n);
      @(posedge clock);
      ev_valid <= 1'b1;
      ev_type <= t;
      ev_nsid <= n;
      @(posedge clock);
      ev_valid <= 1'b0;
   endtask : ev
   task print_verdict;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : print_verdict
   initial begin
      #800000;
      num_errors++;
      print_verdict;
   end
   initial begin
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      foreach (rows[i]) rd(rows[i][43:32], rows[i][31:0]);
      wr(RNQ_OFS_IRQ_MASK, 32'hf);
      ev(8'h01, 32'h11);
      ev(8'h02, 32'h22);
      ev(8'h01, 32'h33);
      rd(RNQ_OFS_LEVEL, 32'h2);
      chk(64'(irq), 64'h1);
      wr(RNQ_OFS_REQ, 32'(RNQ_LOG_ID));
      rd(RNQ_OFS_CNT_LO, 32'h1);
      rd(RNQ_OFS_CNT_HI, 32'h0);
      rd(RNQ_OFS_INFO, 32'h101);
      rd(RNQ_OFS_NSID, 32'h11);
      wr(RNQ_OFS_REQ, 32'(RNQ_LOG_ID));
      rd(RNQ_OFS_CNT_LO, 32'h3);
      rd(RNQ_OFS_INFO, 32'h2);
      rd(RNQ_OFS_LEVEL, 32'h0);
      wr(RNQ_OFS_REQ, 32'(RNQ_LOG_ID));
      for (int a = 4; a <= 16; a += 4) rd(12'(a), 32'h0);
      ev(8'h02, 32'h44);
      wr(RNQ_OFS_REQ, 32'(RNQ_LOG_ID));
      rd(RNQ_OFS_CNT_LO, 32'h4);
      wr(RNQ_OFS_NMASK, 32'h2);
      ev(8'h01, 32'h55);
      rd(RNQ_OFS_LEVEL, 32'h0);
      ev(8'h02, 32'h66);
      wr(RNQ_OFS_REQ, 32'(RNQ_LOG_ID));
      rd(RNQ_OFS_CNT_LO, 32'h5);
      wr(RNQ_OFS_REQ, 32'h81);
      rd(RNQ_OFS_IRQ_STAT, 32'hf);
      wr(RNQ_OFS_IRQ_STAT, 32'hf);
      rd(RNQ_OFS_IRQ_STAT, 32'h0);
      repeat (2) @(posedge clock);
      chk(64'(irq), 64'h0);
      host.xfer(1'b0, 12'h024, 32'h0, q, e);
      chk(64'(e), 64'h1);
      // a second reset mid-run empties the queue and restarts the count
      ev(8'h02, 32'h77);
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      rd(RNQ_OFS_LEVEL, 32'h0);
      ev(8'h02, 32'h88);
      wr(RNQ_OFS_REQ, 32'(RNQ_LOG_ID));
      rd(RNQ_OFS_CNT_LO, 32'h1);
      rd(RNQ_OFS_NSID, 32'h88);
      print_verdict;
   end
endmodule : test_reservation_notification_queue
bind rnq_top rnq_properties #(.DEPTH(DEPTH)) u_props (.clock, .rst, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ev_valid,
   .ev_type, .ev_nsid, .irq);
